/* File: hw/das_top.v */
// Behaviour
// - System pressure under 15: 45 s disarm, 10 s lag, major, immediate shutdown.
// - System pressure over 40: no disarm, 10 s lag, summary and shutdown.
// - Humidity over 5: 180 s disarm, 5 s lag, shutdown after 5 more minutes.
// - Humidity bypass output follows humidity directly, no disarm or lag.
// - Low water float: 15 s disarm, 5 s lag, major, immediate shutdown.
// - High water float: no disarm, 5 s lag, major, immediate shutdown.
// - Line pressure under setting (8): 180 s disarm, 5 s lag, minor.
// - Line pressure over setting (20): no disarm, 5 s lag, minor.
// - Line pressure alarms clear by themselves when condition clears.
// - Any phase under brown-out setting raises power loss at once.
// - Power loss enters standby; once it clears, waits power-on delay, restarts.
// - Water temperature over 160: 1 s lag, major, immediate shutdown.
// - Water temperature under 35: 1 s lag, summary, immediate shutdown.
// - Low temperature stays armed while transfer controller holds standby.
// - A third successive power loss, after two restarts, raises a brownout fault shown as power failure.
// - Tripped compressor breaker: 1 s lag, major, immediate shutdown.
// - High flow: 30 s lag, self-clearing, segregated position 9 and flow warning only.
// - High flow threshold is a software-set per-model value.
// - Majors stop the dryer and set summary; minors keep it running.
// - Humidity is minor first, major once its shutdown delay expires.
`timescale 1ns/100ps
`include "das_map.vh"

module das_top #(
	parameter TICK_CYCLES = `DAS_TICK_CYCLES      // Cycles per second tick
) (
	input  wire        sys_clk,                  // System clock 20 MHz
	input  wire        rst,                      // Async reset, high
	input  wire        clk_en,                   // Freezes all state when low
	input  wire [15:0] sys_press,                // System pressure psig
	input  wire [15:0] line_press,               // Line pressure psig
	input  wire [15:0] humidity,                 // Outlet humidity %RH
	input  wire        water_low,                // Low water float
	input  wire        water_high,               // High water float
	input  wire [15:0] water_temp,               // Leaving water temp F
	input  wire [15:0] phase_a,                  // Phase A volts
	input  wire [15:0] phase_b,                  // Phase B volts
	input  wire [15:0] phase_c,                  // Phase C volts
	input  wire        breaker_trip,             // Compressor breaker tripped
	input  wire [15:0] air_flow,                 // Air flow rate
	input  wire        xfer_standby,             // auto_transfer_controller hold
	input  wire [3:0]  reg_addr,                 // Register address
	input  wire [15:0] reg_wdata,                // Write data
	input  wire        reg_wr,                   // Write strobe
	input  wire        reg_rd,                   // Read strobe
	output reg  [15:0] reg_rdata,                // Read data, cycle after strobe
	output reg         summary_alarm_terminals,  // Summary alarm output
	output reg  [11:0] seg_alarm,                // Segregated alarm outputs
	output reg         shutdown_req,             // Stop compressor
	output reg         run_out,                  // Dryer running
	output reg         rh_bypass,                // Humidity bypass control
	output reg         flow_warn                 // High flow warning display
);

	localparam ST_IDLE  = 2'h0;
	localparam ST_RUN   = 2'h1;
	localparam ST_WAIT  = 2'h2;
	localparam ST_FAULT = 2'h3;

	localparam NQ = 11;

	reg [24:0] tick_cnt_ff;
	reg        tick_ff;
	reg [1:0]  state_ff;
	reg [15:0] since_ff;
	reg [15:0] dly_ff;
	reg [1:0]  tries_ff;
	reg [15:0] rh_dly_ff;
	reg        rh_major_ff;
	reg        pwr_ff;
	reg        start_ff;
	reg [15:0] pwrdly_ff;
	reg [15:0] linelo_ff;
	reg [15:0] linehi_ff;
	reg [15:0] brown_ff;
	reg [15:0] flow_ff;
	reg [15:0] nxt_rdata;
	reg [NQ-1:0] qual_ff;

	wire [NQ-1:0] cond;
	wire [NQ-1:0] armed;
	wire [15:0]   lag_sec [0:NQ-1];
	wire          pwr_low;
	wire          major_any;
	wire          fault = (state_ff == ST_FAULT);

	// Raw threshold comparisons
	assign cond[0]  = sys_press < `DAS_SYS_LO_PSIG;
	assign cond[1]  = sys_press > `DAS_SYS_HI_PSIG;
	assign cond[2]  = humidity > `DAS_RH_MAX_PCT;
	assign cond[3]  = water_low;
	assign cond[4]  = water_high;
	assign cond[5]  = line_press < linelo_ff;
	assign cond[6]  = line_press > linehi_ff;
	assign cond[7]  = water_temp > `DAS_TEMP_HI_F;
	assign cond[8]  = water_temp < `DAS_TEMP_LO_F;
	assign cond[9]  = breaker_trip;
	assign cond[10] = air_flow > flow_ff;
	assign pwr_low  = (phase_a < brown_ff) | (phase_b < brown_ff) | (phase_c < brown_ff);

	// Disarm windows from start-up
	assign armed[0]  = since_ff >= `DAS_DIS_SYSLO_S;
	assign armed[1]  = 1'b1;
	assign armed[2]  = since_ff >= `DAS_DIS_RH_S;
	assign armed[3]  = since_ff >= `DAS_DIS_WLO_S;
	assign armed[4]  = 1'b1;
	assign armed[5]  = since_ff >= `DAS_DIS_LINELO_S;
	assign armed[6]  = 1'b1;
	assign armed[7]  = 1'b1;
	assign armed[8]  = 1'b1;
	assign armed[9]  = 1'b1;
	assign armed[10] = 1'b1;

	// Lag per alarm in seconds, constant nets so no process is needed
	assign lag_sec[0]  = `DAS_LAG_SYS_S;
	assign lag_sec[1]  = `DAS_LAG_SYS_S;
	assign lag_sec[2]  = `DAS_LAG_5_S;
	assign lag_sec[3]  = `DAS_LAG_5_S;
	assign lag_sec[4]  = `DAS_LAG_5_S;
	assign lag_sec[5]  = `DAS_LAG_5_S;
	assign lag_sec[6]  = `DAS_LAG_5_S;
	assign lag_sec[7]  = `DAS_LAG_1_S;
	assign lag_sec[8]  = `DAS_LAG_1_S;
	assign lag_sec[9]  = `DAS_LAG_1_S;
	assign lag_sec[10] = `DAS_LAG_FLOW_S;

	// One-second tick
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tick_cnt_ff <= 25'h0;
			tick_ff     <= 1'b0;
		end else if (clk_en) begin
			if ({7'h0, tick_cnt_ff} == TICK_CYCLES - 1) begin
				tick_cnt_ff <= 25'h0;
				tick_ff     <= 1'b1;
			end else begin
				tick_cnt_ff <= tick_cnt_ff + 25'h1;
				tick_ff     <= 1'b0;
			end
		end
	end

	// Qualifying lag per alarm
	genvar gi;
	generate
		for (gi = 0; gi < NQ; gi = gi + 1) begin : g_lag
			reg [15:0] lag_ff;
			always @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					lag_ff      <= 16'h0;
					qual_ff[gi] <= 1'b0;
				end else if (clk_en) begin
					if (!(cond[gi] && armed[gi] && (state_ff == ST_RUN || gi == 8))) begin
						lag_ff      <= 16'h0;
						qual_ff[gi] <= 1'b0;
					end else if (tick_ff && !qual_ff[gi]) begin
						if (lag_ff + 16'h1 >= lag_sec[gi])
							qual_ff[gi] <= 1'b1;
						lag_ff <= lag_ff + 16'h1;
					end
				end
			end
		end
	endgenerate

	// Humidity shutdown delay, minor then major
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rh_dly_ff   <= 16'h0;
			rh_major_ff <= 1'b0;
		end else if (clk_en) begin
			if (!qual_ff[2]) begin
				rh_dly_ff   <= 16'h0;
				rh_major_ff <= 1'b0;
			end else if (tick_ff && !rh_major_ff) begin
				if (rh_dly_ff + 16'h1 >= `DAS_RH_SHUT_S)
					rh_major_ff <= 1'b1;
				rh_dly_ff <= rh_dly_ff + 16'h1;
			end
		end
	end

	assign major_any = qual_ff[0] | qual_ff[1] | rh_major_ff | qual_ff[3] | qual_ff[4]
		| qual_ff[7] | qual_ff[8] | qual_ff[9] | pwr_low | fault;

	// Run sequence with restart counting
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_ff <= ST_IDLE;
			since_ff <= 16'h0;
			dly_ff   <= 16'h0;
			tries_ff <= 2'h0;
			pwr_ff   <= 1'b0;
		end else if (clk_en) begin
			pwr_ff <= pwr_low;
			if (tick_ff && since_ff != 16'hffff)
				since_ff <= since_ff + 16'h1;
			case (state_ff)
				ST_IDLE: begin
					if (start_ff && !pwr_low) begin
						state_ff <= ST_RUN;
						since_ff <= 16'h0;
						tries_ff <= 2'h0;
					end
				end
				ST_RUN: begin
					if (pwr_low) begin
						state_ff <= ST_WAIT;
						dly_ff   <= 16'h0;
					end else if (!start_ff) begin
						state_ff <= ST_IDLE;
					end else if (since_ff >= `DAS_DIS_LINELO_S) begin
						tries_ff <= 2'h0;
					end
				end
				ST_WAIT: begin
					if (pwr_low) begin
						dly_ff <= 16'h0;
					end else if (tick_ff) begin
						if (dly_ff + 16'h1 >= pwrdly_ff) begin
							if (tries_ff + 2'h1 == `DAS_MAX_RESTART) begin
								state_ff <= ST_FAULT;
							end else begin
								state_ff <= ST_RUN;
								since_ff <= 16'h0;
								tries_ff <= tries_ff + 2'h1;
							end
						end
						dly_ff <= dly_ff + 16'h1;
					end
				end
				ST_FAULT: begin
					if (reg_wr && reg_addr == `DAS_REG_CTRL && reg_wdata[`DAS_CTRL_CLRFLT]) begin
						state_ff <= ST_IDLE;
						tries_ff <= 2'h0;
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// Register writes
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			start_ff  <= 1'b0;
			pwrdly_ff <= `DAS_RST_PWRDLY;
			linelo_ff <= `DAS_RST_LINELO;
			linehi_ff <= `DAS_RST_LINEHI;
			brown_ff  <= `DAS_RST_BROWN;
			flow_ff   <= `DAS_RST_FLOW;
		end else if (clk_en && reg_wr) begin
			case (reg_addr)
				`DAS_REG_CTRL:   start_ff  <= reg_wdata[`DAS_CTRL_START];
				`DAS_REG_PWRDLY: pwrdly_ff <= reg_wdata;
				`DAS_REG_LINELO: linelo_ff <= reg_wdata;
				`DAS_REG_LINEHI: linehi_ff <= reg_wdata;
				`DAS_REG_BROWN:  brown_ff  <= reg_wdata;
				`DAS_REG_FLOW:   flow_ff   <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Read mux
	always @* begin
		nxt_rdata = 16'h0;
		case (reg_addr)
			`DAS_REG_CTRL:   nxt_rdata = {15'h0, start_ff};
			`DAS_REG_PWRDLY: nxt_rdata = pwrdly_ff;
			`DAS_REG_LINELO: nxt_rdata = linelo_ff;
			`DAS_REG_LINEHI: nxt_rdata = linehi_ff;
			`DAS_REG_BROWN:  nxt_rdata = brown_ff;
			`DAS_REG_FLOW:   nxt_rdata = flow_ff;
			`DAS_REG_STAT:   nxt_rdata = {10'h0, tries_ff, state_ff, rh_major_ff, pwr_ff};
			`DAS_REG_SEG:    nxt_rdata = {4'h0, seg_alarm};
			`DAS_REG_ACT:    nxt_rdata = {5'h0, qual_ff};
			default:         nxt_rdata = 16'h0;
		endcase
	end

	// Registered outputs
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reg_rdata               <= 16'h0;
			summary_alarm_terminals <= 1'b0;
			seg_alarm               <= 12'h0;
			shutdown_req            <= 1'b0;
			run_out                 <= 1'b0;
			rh_bypass               <= 1'b0;
			flow_warn               <= 1'b0;
		end else if (clk_en) begin
			reg_rdata <= reg_rd ? nxt_rdata : 16'h0;
			summary_alarm_terminals <= major_any | qual_ff[2] | qual_ff[5] | qual_ff[6];
			seg_alarm[`DAS_SEG_SYSLO]  <= qual_ff[0];
			seg_alarm[`DAS_SEG_SYSHI]  <= qual_ff[1];
			seg_alarm[`DAS_SEG_RH]     <= qual_ff[2];
			seg_alarm[`DAS_SEG_WLO]    <= qual_ff[3];
			seg_alarm[`DAS_SEG_WHI]    <= qual_ff[4];
			seg_alarm[`DAS_SEG_LINELO] <= qual_ff[5];
			seg_alarm[`DAS_SEG_LINEHI] <= qual_ff[6];
			seg_alarm[`DAS_SEG_PWR]    <= pwr_low | fault;
			seg_alarm[`DAS_SEG_THI]    <= qual_ff[7];
			seg_alarm[`DAS_SEG_FLOW]   <= qual_ff[10];
			seg_alarm[`DAS_SEG_TLO]    <= qual_ff[8];
			seg_alarm[`DAS_SEG_BRK]    <= qual_ff[9];
			shutdown_req <= major_any;
			run_out      <= (state_ff == ST_RUN) && !major_any;
			rh_bypass    <= cond[2];
			flow_warn    <= qual_ff[10];
		end
	end

endmodule

/* File: pkg/das_map.vh */
`ifndef DAS_MAP_VH
`define DAS_MAP_VH

// Clock and tick
`define DAS_CLK_HZ          20000000
`define DAS_TICK_CYCLES     (`DAS_CLK_HZ)

// Register offsets
`define DAS_REG_CTRL        4'h0
`define DAS_REG_PWRDLY      4'h1
`define DAS_REG_LINELO      4'h2
`define DAS_REG_LINEHI      4'h3
`define DAS_REG_BROWN       4'h4
`define DAS_REG_FLOW        4'h5
`define DAS_REG_STAT        4'h6
`define DAS_REG_SEG         4'h7
`define DAS_REG_ACT         4'h8

// Reset values of threshold registers
`define DAS_RST_LINELO      16'h0008
`define DAS_RST_LINEHI      16'h0014
`define DAS_RST_BROWN       16'h00b4
`define DAS_RST_FLOW        16'h1388
`define DAS_RST_PWRDLY      16'h000a

// Fixed thresholds
`define DAS_SYS_LO_PSIG     16'h000f
`define DAS_SYS_HI_PSIG     16'h0028
`define DAS_RH_MAX_PCT      16'h0005
`define DAS_TEMP_HI_F       16'h00a0
`define DAS_TEMP_LO_F       16'h0023

// Disarm periods in seconds
`define DAS_DIS_SYSLO_S     16'h002d
`define DAS_DIS_RH_S        16'h00b4
`define DAS_DIS_WLO_S       16'h000f
`define DAS_DIS_LINELO_S    16'h00b4

// Lags in seconds
`define DAS_LAG_SYS_S       16'h000a
`define DAS_LAG_5_S         16'h0005
`define DAS_LAG_1_S         16'h0001
`define DAS_LAG_FLOW_S      16'h001e
`define DAS_RH_SHUT_MIN     16'h0005
`define DAS_RH_SHUT_S       (`DAS_RH_SHUT_MIN * 16'h003c)

// Successive power losses that raise the brownout fault
`define DAS_MAX_RESTART     2'h3

// Segregated output positions
`define DAS_SEG_SYSLO       0
`define DAS_SEG_SYSHI       1
`define DAS_SEG_RH          2
`define DAS_SEG_WLO         3
`define DAS_SEG_WHI         4
`define DAS_SEG_LINELO      5
`define DAS_SEG_LINEHI      6
`define DAS_SEG_PWR         7
`define DAS_SEG_THI         8
`define DAS_SEG_FLOW        9
`define DAS_SEG_TLO         10
`define DAS_SEG_BRK         11

// Control register fields
`define DAS_CTRL_START      0
`define DAS_CTRL_CLRFLT     1

`endif

/* File: tb/das_props_properties.sv */
`timescale 1ns/100ps
module das_props #(
	parameter TICK_CYCLES = 20  // Cycles per tick
) (
	input wire        sys_clk,                  // Clock
	input wire        rst,                      // Reset
	input wire        clk_en,                   // Enable
	input wire [15:0] line_press,               // Line psig
	input wire [15:0] humidity,                 // %RH
	input wire [15:0] water_temp,               // Water F
	input wire [15:0] phase_a,                  // Phase A V
	input wire [11:0] seg_alarm,                // Segregated
	input wire        summary_alarm_terminals,  // Summary
	input wire        shutdown_req,             // Stop
	input wire        run_out,                  // Running
	input wire        rh_bypass,                // Bypass
	input wire        flow_warn                 // Flow warning
);
	reg [15:0] hi_ff;   // Cycles over line high
	reg [15:0] arm_ff;  // Same, while running
	reg [15:0] lo_ff;   // Cycles under low temp
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// Run lengths of the conditions, too long for repetition
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			hi_ff <= 16'h0000;
			arm_ff <= 16'h0000;
			lo_ff <= 16'h0000;
		end else begin
			hi_ff <= (line_press > 16'h0014) ? hi_ff + 16'h0001 : 16'h0000;
			arm_ff <= (line_press > 16'h0014 && run_out) ? arm_ff + 16'h0001 : 16'h0000;
			lo_ff <= (water_temp < 16'h0023) ? lo_ff + 16'h0001 : 16'h0000;
		end
	end

	flow_seg_a: assert property (flow_warn == seg_alarm[9])
		else $error("flow warning apart from its position");
	flow_quiet_a: assert property ((seg_alarm == 12'h200) [*3] |-> !summary_alarm_terminals && !shutdown_req)
		else $error("flow warning reached summary or stop");
	rh_follow_a: assert property (!$past(rst) && $past(clk_en) |-> rh_bypass == ($past(humidity) > 16'h0005))
		else $error("bypass not following humidity");
	pwr_fast_a: assert property (run_out && clk_en && phase_a < 16'h00b4 |-> ##[1:3] seg_alarm[7] && shutdown_req)
		else $error("power loss late");
	major_stop_a: assert property (|(seg_alarm & 12'hd9b) |-> ##[0:2] shutdown_req)
		else $error("major without stop");
	stop_run_a: assert property ($rose(shutdown_req) |-> ##[0:1] !run_out)
		else $error("still running on stop");
	line_clear_a: assert property (seg_alarm[6] && line_press <= 16'h0014 |-> ##[1:3] !seg_alarm[6])
		else $error("line alarm held");
	lag_min_a: assert property ($rose(seg_alarm[6]) |-> hi_ff >= 4 * TICK_CYCLES)
		else $error("line alarm early");
	lag_max_a: assert property (arm_ff == 5 * TICK_CYCLES + 4 |-> seg_alarm[6])
		else $error("line alarm late");
	tlo_armed_a: assert property (lo_ff == TICK_CYCLES + 4 |-> seg_alarm[10] && shutdown_req)
		else $error("low temp alarm late");
	cover property ($rose(seg_alarm[7]));
	cover property ($rose(flow_warn));
	cover property ($rose(shutdown_req) ##1 seg_alarm[2]);
endmodule

/* File: tb/das_sensor_model.sv */
`timescale 1ns/100ps
module das_sensor_model (
	input  wire [3:0]  fault,         // Condition code
	input  wire [2:0]  jit,           // Noise
	output wire [15:0] sys_press,     // psig
	output wire [15:0] line_press,    // psig
	output wire [15:0] humidity,      // %RH
	output wire        water_low,     // Low float
	output wire        water_high,    // High float
	output wire [15:0] water_temp,    // F
	output wire [15:0] phase_a,       // V
	output wire [15:0] phase_b,       // V
	output wire [15:0] phase_c,       // V
	output wire        breaker_trip,  // Tripped
	output wire [15:0] air_flow       // Flow
);
	wire [15:0] n = {13'h0000, jit};  // Noise stays inside every band
	// Nominal readings, the coded one pushed out of band
	assign sys_press = (fault == 4'h1) ? 16'h000a : (fault == 4'h2) ? 16'h002d : 16'h0019 + n;
	assign line_press = (fault == 4'h6) ? 16'h0005 : (fault == 4'h7) ? 16'h0019 : 16'h000c + n;
	assign humidity = (fault == 4'h3) ? 16'h0009 : {14'h0000, jit[1:0]};
	assign water_low = (fault == 4'h4);
	assign water_high = (fault == 4'h5);
	assign water_temp = (fault == 4'h9) ? 16'h00aa : (fault == 4'ha) ? 16'h001e : 16'h005a + n;
	assign phase_a = (fault == 4'h8) ? 16'h0096 : 16'h00d0 + n;
	assign phase_b = 16'h00d0 + n;
	assign phase_c = (fault == 4'hd) ? 16'h0096 : 16'h00d0 + n;
	assign breaker_trip = (fault == 4'hb);
	assign air_flow = (fault == 4'hc) ? 16'h0400 : 16'h0100 + n;
endmodule

/* File: tb/tb_das_top.sv */
`timescale 1ns/100ps
module tb_das_top;
	localparam int T = 20;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        clk_en = 1'b1;
	logic        xfer_standby = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [3:0]  fault = 4'h0;
	logic [2:0]  jit = 3'h0;
	logic [15:0] v, d;
	wire  [15:0] sys_press, line_press, humidity, water_temp, phase_a, phase_b, phase_c, air_flow, reg_rdata;
	wire         water_low, water_high, breaker_trip, summary_alarm_terminals, shutdown_req, run_out, rh_bypass;
	wire         flow_warn;
	wire  [11:0] seg_alarm;
	int          n_mismatch = 0;
	int          comparisons = 0;
	int          c, t;
	int          lag_s [1:12] = '{10, 10, 5, 5, 5, 5, 5, 0, 1, 1, 1, 30};
	int          bit_of [1:12] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 10, 11, 9};
	int          stops [1:12] = '{1, 1, 0, 1, 1, 0, 0, 1, 1, 1, 1, 0};
	int          codes [$] = '{1, 2, 3, 4, 5, 6, 7, 9, 10, 11, 12};
	logic [3:0]  ra [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hf};
	logic [15:0] rv [8] = '{16'h000a, 16'h0008, 16'h0014, 16'h00b4, 16'h1388, 16'h0000, 16'h0000, 16'h0000};

	// 20 MHz clock
	always #25 sys_clk = ~sys_clk;

	das_top #(.TICK_CYCLES(T)) i_das_top (
		.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .sys_press(sys_press), .line_press(line_press),
		.humidity(humidity), .water_low(water_low), .water_high(water_high), .water_temp(water_temp),
		.phase_a(phase_a), .phase_b(phase_b), .phase_c(phase_c), .breaker_trip(breaker_trip),
		.air_flow(air_flow), .xfer_standby(xfer_standby), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .summary_alarm_terminals(summary_alarm_terminals),
		.seg_alarm(seg_alarm), .shutdown_req(shutdown_req), .run_out(run_out), .rh_bypass(rh_bypass),
		.flow_warn(flow_warn));
	das_sensor_model i_das_sensor_model (
		.fault(fault), .jit(jit), .sys_press(sys_press), .line_press(line_press), .humidity(humidity),
		.water_low(water_low), .water_high(water_high), .water_temp(water_temp), .phase_a(phase_a),
		.phase_b(phase_b), .phase_c(phase_c), .breaker_trip(breaker_trip), .air_flow(air_flow));

	// Edge wait, then settle past the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] w);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= w;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] r);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		r = reg_rdata;
	endtask
	task automatic tally_and_finish;
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		void'($urandom(32'h916a5d46));
		fork
			forever begin
				@(posedge sys_clk);
				jit <= 3'($urandom);
			end
		join_none
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		wr(4'h7, 16'hffff);
		v = 16'($urandom);
		wr(4'h5, v);
		rd(4'h5, d);
		chk(d, v);
		wr(4'h5, 16'h1388);
		foreach (ra[i]) begin
			rd(ra[i], d);
			chk(d, rv[i]);
		end
		@(posedge sys_clk);
		fault <= 4'h3;
		cyc(3);
		chk(rh_bypass, 1'b1);
		chk(seg_alarm, 16'h0000);
		@(posedge sys_clk);
		fault <= 4'h0;
		wr(4'h0, 16'h0001);
		@(posedge sys_clk);
		fault <= 4'h1;
		cyc(40 * T);
		chk(seg_alarm, 16'h0000);
		cyc(17 * T);
		chk(seg_alarm, 16'h0001);
		@(posedge sys_clk);
		fault <= 4'h0;
		cyc(125 * T);
		foreach (codes[i]) begin
			c = codes[i];
			if (c == 12) wr(4'h5, 16'h0300);
			@(posedge sys_clk);
			fault <= 4'(c);
			xfer_standby <= (c == 10);
			cyc(lag_s[c] * T / 2);
			@(posedge sys_clk);
			fault <= 4'h0;
			cyc(2);
			@(posedge sys_clk);
			fault <= 4'(c);
			t = 0;
			while (seg_alarm[bit_of[c]] !== 1'b1 && t < lag_s[c] * T + 9) begin
				cyc(1);
				t++;
			end
			chk(t >= (lag_s[c] - 1) * T && t <= lag_s[c] * T + 4, 1'b1);
			cyc(2 * T);
			chk(seg_alarm, 16'(1 << bit_of[c]));
			chk(summary_alarm_terminals, c != 12);
			chk(shutdown_req, stops[c]);
			chk(run_out, !stops[c]);
			chk(flow_warn, c == 12);
			rd(4'h7, d);
			chk(d, 16'(1 << bit_of[c]));
			if (c == 3) begin
				cyc(297 * T - 10);
				chk(shutdown_req, 1'b0);
				cyc(T + 14);
				chk(shutdown_req, 1'b1);
			end
			@(posedge sys_clk);
			fault <= 4'h0;
			xfer_standby <= 1'b0;
			cyc(5);
			chk(seg_alarm, 16'h0000);
			if (c == 12) wr(4'h5, 16'h1388);
		end
		wr(4'h1, 16'h0002);
		for (int k = 0; k < 3; k++) begin
			@(posedge sys_clk);
			fault <= (k == 1) ? 4'hd : 4'h8;
			cyc(3);
			chk(seg_alarm, 16'h0080);
			chk(shutdown_req, 1'b1);
			@(posedge sys_clk);
			fault <= 4'h0;
			cyc(3 * T + 6);
			chk(run_out, k < 2);
			chk(seg_alarm[7], k == 2);
		end
		rd(4'h6, d);
		chk(d[3:2], 2'h3);
		wr(4'h0, 16'h0003);
		cyc(4);
		chk(seg_alarm, 16'h0000);
		// Enable low freezes detection and sequence
		@(posedge sys_clk);
		clk_en <= 1'b0;
		fault <= 4'h8;
		cyc(4);
		chk(seg_alarm, 16'h0000);
		chk(shutdown_req, 1'b0);
		@(posedge sys_clk);
		fault <= 4'h0;
		@(posedge sys_clk);
		clk_en <= 1'b1;
		cyc(3);
		chk(run_out, 1'b1);
		chk(seg_alarm, 16'h0000);
		tally_and_finish;
	end

	// Hang guard, well past the expected run
	initial begin
		cyc(40000);
		n_mismatch++;
		tally_and_finish;
	end
endmodule

bind das_top das_props #(.TICK_CYCLES(TICK_CYCLES)) i_das_props (
	.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .line_press(line_press), .humidity(humidity),
	.water_temp(water_temp), .phase_a(phase_a), .seg_alarm(seg_alarm),
	.summary_alarm_terminals(summary_alarm_terminals), .shutdown_req(shutdown_req), .run_out(run_out),
	.rh_bypass(rh_bypass), .flow_warn(flow_warn));
